// *** core/vemt_map.svh ***
// register offsets, bit positions, reset values and timing counts of the mode/timing bank
// assumes an 8-bit register space reached by a 5-bit subaddress
`ifndef VEMT_MAP_SVH
`define VEMT_MAP_SVH
`define VEMT_OFS_OUTPUT_POWER 5'h04
`define VEMT_OFS_TIMING_ROLE 5'h07
`define VEMT_OFS_SYNC_SHAPE 5'h08
`define VEMT_RST_OUTPUT_POWER 8'h00
`define VEMT_RST_TIMING_ROLE 8'h00
`define VEMT_RST_SYNC_SHAPE 8'h00
`define VEMT_B_FMT 0
`define VEMT_B_YPBPR 1
`define VEMT_B_SYNCALL 2
`define VEMT_B_LONGV 3
`define VEMT_B_PED 4
`define VEMT_B_BFILT 5
`define VEMT_B_SLEEP 6
`define VEMT_B_MASTER 0
`define VEMT_B_BLANK 3
`define VEMT_B_PIXPORT 6
`define VEMT_B_TCR 7
`define VEMT_VS_PAL_HALFLINES 3'h5
`define VEMT_VS_NTSC_HALFLINES 3'h6
`define VEMT_LUMA_STEP_NS 74
`define VEMT_CLOCK_NS 25
`define VEMT_LUMA_STEP_CYC ((`VEMT_LUMA_STEP_NS + `VEMT_CLOCK_NS - 1) / `VEMT_CLOCK_NS)
`endif

// *** core/vemt_pkg.sv ***
// types of the mode/timing register bank
// used by vemt_regs; constants live in vemt_map.svh
package vemt_pkg;
    typedef enum logic [3:0] {
        BusIdle, BusAddr, BusAddrAck, BusSub, BusSubAck, BusWr, BusWrAck, BusRd, BusRdAck
    } vemt_bus_state_t;

    typedef struct packed {
        logic componentOut;
        logic ypbprSel;
        logic syncOnAll;
        logic [2:0] vsyncHalfLines;
        logic pedestalOn;
        logic blankFilterOn;
        logic master;
        logic [1:0] timingMode;
        logic blankInputHonoured;
        logic [3:0] lumaDelayCycles;
        logic pixelPortCfg;
        logic [1:0] hsyncWidthSel;
        logic [1:0] hsyncFieldOffset;
        logic [1:0] hsyncFieldEdgeDelay;
        logic [1:0] vsyncWidthSel;
        logic [1:0] hsyncPixelOffset;
    } vemt_cfg_t;
endpackage : vemt_pkg

// *** core/vemt_regs.sv ***
// mode/timing control bank of a video encoder, reached over the two-wire serial bus
// assumes scl/sda arrive asynchronously, lineStart is a one-cycle pulse on this clock
// Notes on behaviour
// R1: one mode bit picks composite or component (RGB/YPbPr) output arrangement.
// R2: a second mode bit turns component outputs from RGB into YPbPr.
// R3: sync-on-color bit puts sync on red, green and blue outputs.
// R4: long vertical bit in slave accepts 2.5 line PAL, 3 line NTSC vsync.
// R5: long vertical bit in master drives 3 line NTSC, 2.5 line PAL vsync.
// R6: pedestal bit adds NTSC setup; ignored in PAL.
// R7: filter bit enables blanking-region filter outside active video.
// R8: sleep bit enters sleep; registers stay readable and writable.
// R9: sleep ends when the bit clears or on reset.
// R10: host writes zero to the reserved top mode bit.
// R11: first timing register is readable and writable, reads return contents.
// R12: bit zero of first timing register picks master or slave.
// R13: two-bit field selects the timing mode.
// R14: one bit decides if blank input is honoured in slave mode.
// R15: luma delay field delays luma by 74 ns per count; the code rounds each count up to three 25 ns clocks (75 ns).
// R16: host writes zero to the pixel port bit.
// R17: low-high-low on counter reset bit clears the timing counters.
// R18: host pulses counter reset after power-up, reset, and mode change.
// R19: second timing register read/write; low field sets master hsync width.
// R20: next field shifts hsync against field/vsync output.
// R21: bits 5:4 are field-edge delay in mode 1, vsync width in mode 2.
// R22: top field shifts hsync against pixel data, master and slave.
// R23: settings apply at line start, whole register at once; the sleep bit and the counter reset bit act at once on the host copy instead.
`include "vemt_map.svh"
`timescale 1ns/1ps
`default_nettype none
module vemt_regs #(
    parameter logic [6:0] DEV_ADDR = 7'h2a // arbitrary bus address
) (
    input wire logic clock, // 40 MHz
    input wire logic arst_n, // asynchronous reset
    input wire logic sclIn, // serial clock pin
    input wire logic sdaIn, // serial data pin level
    output logic sdaOut, // always low when driven
    output logic sdaOe_n, // low while pulling sda low
    input wire logic palMode, // video standard from the encoder, 1 = PAL
    input wire logic lineStart, // start of a video line
    output vemt_pkg::vemt_cfg_t cfg, // applied configuration
    output logic sleepActive, // low-power state
    output logic timingCounterClear // one-cycle pulse
);
    vemt_pkg::vemt_bus_state_t st_q, st_d;
    logic [2:0] sclSync_q, sclSync_d;
    logic [2:0] sdaSync_q, sdaSync_d;
    logic sclF_q, sclF_d;
    logic sdaF_q, sdaF_d;
    logic [2:0] bitCnt_q, bitCnt_d;
    logic [7:0] shift_q, shift_d;
    logic [4:0] subAddr_q, subAddr_d;
    logic rdMode_q, rdMode_d;
    logic drive_q, drive_d;
    // set by the first address bit after a start
    logic addrSeen_q, addrSeen_d;
    logic [7:0] outPow_q, outPow_d;
    logic [7:0] timRole_q, timRole_d;
    logic [7:0] syncShape_q, syncShape_d;
    logic [7:0] outPowA_q, outPowA_d;
    logic [7:0] timRoleA_q, timRoleA_d;
    logic [7:0] syncShapeA_q, syncShapeA_d;
    logic tcrArmed_q, tcrArmed_d;
    logic tcrClr_q, tcrClr_d;
    logic sleep_q, sleep_d;
    vemt_pkg::vemt_cfg_t cfg_q, cfg_d;
    logic sclRise, sclFall;
    logic startCond, stopCond;

    // unmapped subaddresses read as zero but are still acked, so a host scan never stalls
    function automatic logic [7:0] readReg(input logic [4:0] a, input logic [7:0] p,
                                           input logic [7:0] t, input logic [7:0] s);
        logic [7:0] v;
        v = 8'h00;
        unique case (a)
            `VEMT_OFS_OUTPUT_POWER: v = p;
            `VEMT_OFS_TIMING_ROLE: v = t; // [R11]
            `VEMT_OFS_SYNC_SHAPE: v = s; // [R19]
            default: v = 8'h00;
        endcase
        return v;
    endfunction : readReg

    // pins: three stages, a level counts once stages two and three agree
    always_comb begin
        sclSync_d = {sclSync_q[1:0], sclIn};
        sdaSync_d = {sdaSync_q[1:0], sdaIn};
        sclF_d = (sclSync_q[1] == sclSync_q[2]) ? sclSync_q[2] : sclF_q;
        sdaF_d = (sdaSync_q[1] == sdaSync_q[2]) ? sdaSync_q[2] : sdaF_q;
    end

    assign sclRise = sclF_d & ~sclF_q;
    assign sclFall = ~sclF_d & sclF_q;
    assign startCond = sclF_q & sclF_d & sdaF_q & ~sdaF_d;
    assign stopCond = sclF_q & sclF_d & ~sdaF_q & sdaF_d;

    // serial slave with auto-incrementing subaddress
    always_comb begin
        st_d = st_q;
        bitCnt_d = bitCnt_q;
        shift_d = shift_q;
        subAddr_d = subAddr_q;
        rdMode_d = rdMode_q;
        drive_d = drive_q;
        addrSeen_d = addrSeen_q;
        outPow_d = outPow_q;
        timRole_d = timRole_q;
        syncShape_d = syncShape_q;
        if (startCond) begin
            st_d = vemt_pkg::BusAddr;
            bitCnt_d = 3'h0;
            drive_d = 1'b0;
            addrSeen_d = 1'b0;
        end else if (stopCond) begin
            st_d = vemt_pkg::BusIdle;
            drive_d = 1'b0;
        end else if (sclRise) begin
            unique case (st_q)
                vemt_pkg::BusAddr, vemt_pkg::BusSub, vemt_pkg::BusWr, vemt_pkg::BusRd: begin
                    shift_d = (st_q == vemt_pkg::BusRd) ? shift_q : {shift_q[6:0], sdaF_d};
                    bitCnt_d = bitCnt_q + 3'h1;
                    if (st_q == vemt_pkg::BusAddr) begin
                        addrSeen_d = 1'b1;
                    end
                end
                vemt_pkg::BusRdAck: rdMode_d = ~sdaF_d; // master ack keeps reading
                default: ;
            endcase
        end else if (sclFall) begin
            unique case (st_q)
                vemt_pkg::BusAddr: begin
                    // the scl fall that closes a start comes before any bit: not a full byte
                    if (bitCnt_q == 3'h0 && addrSeen_q) begin
                        if (shift_q[7:1] == DEV_ADDR) begin
                            st_d = vemt_pkg::BusAddrAck;
                            rdMode_d = shift_q[0];
                            drive_d = 1'b1;
                        end else begin
                            st_d = vemt_pkg::BusIdle;
                        end
                    end
                end
                vemt_pkg::BusSub: begin
                    if (bitCnt_q == 3'h0) begin
                        subAddr_d = shift_q[4:0];
                        st_d = vemt_pkg::BusSubAck;
                        drive_d = 1'b1;
                    end
                end
                vemt_pkg::BusWr: begin
                    if (bitCnt_q == 3'h0) begin
                        // writes stay open during sleep [R8]
                        unique case (subAddr_q)
                            `VEMT_OFS_OUTPUT_POWER: outPow_d = shift_q; // [R10]
                            `VEMT_OFS_TIMING_ROLE: timRole_d = shift_q; // [R11] [R16]
                            `VEMT_OFS_SYNC_SHAPE: syncShape_d = shift_q; // [R19]
                            default: ;
                        endcase
                        subAddr_d = subAddr_q + 5'h01;
                        st_d = vemt_pkg::BusWrAck;
                        drive_d = 1'b1;
                    end
                end
                vemt_pkg::BusAddrAck: begin
                    if (rdMode_q) begin
                        shift_d = readReg(subAddr_q, outPow_q, timRole_q, syncShape_q);
                        drive_d = ~shift_d[7];
                        st_d = vemt_pkg::BusRd;
                    end else begin
                        drive_d = 1'b0;
                        st_d = vemt_pkg::BusSub;
                    end
                    bitCnt_d = 3'h0;
                end
                vemt_pkg::BusSubAck, vemt_pkg::BusWrAck: begin
                    drive_d = 1'b0;
                    bitCnt_d = 3'h0;
                    st_d = vemt_pkg::BusWr;
                end
                vemt_pkg::BusRd: begin
                    if (bitCnt_q == 3'h0) begin
                        drive_d = 1'b0;
                        st_d = vemt_pkg::BusRdAck;
                    end else begin
                        shift_d = {shift_q[6:0], 1'b0};
                        drive_d = ~shift_q[6];
                    end
                end
                vemt_pkg::BusRdAck: begin
                    // a master nack ends the read; the next read restarts at the last subaddress read
                    if (rdMode_q) begin
                        subAddr_d = subAddr_q + 5'h01;
                        shift_d = readReg(subAddr_d, outPow_q, timRole_q, syncShape_q);
                        drive_d = ~shift_d[7];
                        bitCnt_d = 3'h0;
                        st_d = vemt_pkg::BusRd;
                    end else begin
                        st_d = vemt_pkg::BusIdle;
                    end
                end
                default: ;
            endcase
        end
    end

    // video side: a whole register lands only at a line start, never mid-line
    always_comb begin
        outPowA_d = lineStart ? outPow_q : outPowA_q; // [R23]
        timRoleA_d = lineStart ? timRole_q : timRoleA_q; // [R23]
        syncShapeA_d = lineStart ? syncShape_q : syncShapeA_q; // [R23]
        // sleep acts at once so a clear wakes even with no line timing running
        sleep_d = outPow_q[`VEMT_B_SLEEP]; // [R8] [R9]
        // counter reset works on the host copy: the pulse is too short to wait for a line
        tcrArmed_d = timRole_q[`VEMT_B_TCR] ? 1'b1 : 1'b0;
        tcrClr_d = tcrArmed_q & ~timRole_q[`VEMT_B_TCR]; // [R17]
    end

    // cfg is registered so the video side never sees a mix of old and new fields
    always_comb begin
        cfg_d = '0;
        cfg_d.componentOut = outPowA_q[`VEMT_B_FMT]; // [R1]
        cfg_d.ypbprSel = outPowA_q[`VEMT_B_YPBPR]; // [R2]
        cfg_d.syncOnAll = outPowA_q[`VEMT_B_SYNCALL]; // [R3]
        if (outPowA_q[`VEMT_B_LONGV]) begin
            // same length whether accepted as slave or driven as master [R4] [R5]
            cfg_d.vsyncHalfLines = palMode ? `VEMT_VS_PAL_HALFLINES : `VEMT_VS_NTSC_HALFLINES;
        end
        cfg_d.pedestalOn = outPowA_q[`VEMT_B_PED] & ~palMode; // [R6]
        cfg_d.blankFilterOn = outPowA_q[`VEMT_B_BFILT]; // [R7]
        cfg_d.master = timRoleA_q[`VEMT_B_MASTER]; // [R12]
        cfg_d.timingMode = timRoleA_q[2:1]; // [R13]
        cfg_d.blankInputHonoured = timRoleA_q[`VEMT_B_BLANK] & ~timRoleA_q[`VEMT_B_MASTER]; // [R14]
        cfg_d.lumaDelayCycles = 4'(timRoleA_q[5:4] * `VEMT_LUMA_STEP_CYC); // [R15]
        cfg_d.pixelPortCfg = timRoleA_q[`VEMT_B_PIXPORT];
        cfg_d.hsyncWidthSel = syncShapeA_q[1:0]; // [R19]
        cfg_d.hsyncFieldOffset = syncShapeA_q[3:2]; // [R20]
        cfg_d.hsyncFieldEdgeDelay = (timRoleA_q[2:1] == 2'h1) ? syncShapeA_q[5:4] : 2'h0; // [R21]
        cfg_d.vsyncWidthSel = (timRoleA_q[2:1] == 2'h2) ? syncShapeA_q[5:4] : 2'h0; // [R21]
        cfg_d.hsyncPixelOffset = syncShapeA_q[7:6]; // [R22]
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            sclSync_q <= 3'h7;
            sdaSync_q <= 3'h7;
            sclF_q <= 1'b1;
            sdaF_q <= 1'b1;
            st_q <= vemt_pkg::BusIdle;
            bitCnt_q <= 3'h0;
            shift_q <= 8'h00;
            subAddr_q <= 5'h00;
            rdMode_q <= 1'b0;
            drive_q <= 1'b0;
            addrSeen_q <= 1'b0;
            outPow_q <= `VEMT_RST_OUTPUT_POWER; // reset leaves sleep [R9]
            timRole_q <= `VEMT_RST_TIMING_ROLE;
            syncShape_q <= `VEMT_RST_SYNC_SHAPE;
            outPowA_q <= `VEMT_RST_OUTPUT_POWER;
            timRoleA_q <= `VEMT_RST_TIMING_ROLE;
            syncShapeA_q <= `VEMT_RST_SYNC_SHAPE;
            sleep_q <= 1'b0;
            tcrArmed_q <= 1'b0;
            tcrClr_q <= 1'b0;
            cfg_q <= '0;
        end else begin
            sclSync_q <= sclSync_d;
            sdaSync_q <= sdaSync_d;
            sclF_q <= sclF_d;
            sdaF_q <= sdaF_d;
            st_q <= st_d;
            bitCnt_q <= bitCnt_d;
            shift_q <= shift_d;
            subAddr_q <= subAddr_d;
            rdMode_q <= rdMode_d;
            drive_q <= drive_d;
            addrSeen_q <= addrSeen_d;
            outPow_q <= outPow_d;
            timRole_q <= timRole_d;
            syncShape_q <= syncShape_d;
            outPowA_q <= outPowA_d;
            timRoleA_q <= timRoleA_d;
            syncShapeA_q <= syncShapeA_d;
            sleep_q <= sleep_d;
            tcrArmed_q <= tcrArmed_d;
            tcrClr_q <= tcrClr_d;
            cfg_q <= cfg_d;
        end
    end

    // open drain: only ever pulls low, the pull-up supplies the one
    assign sdaOut = 1'b0;
    assign sdaOe_n = ~drive_q;
    assign cfg = cfg_q;
    assign sleepActive = sleep_q;
    assign timingCounterClear = tcrClr_q;
endmodule : vemt_regs
`default_nettype wire

// *** verification/vemt_host.sv ***
// two-wire bus host model, bit-banged with eight clocks per scl phase of a data bit
// assumes sdaLvl is the wired-AND sda level with a pull-up
`timescale 1ns/1ps
`default_nettype none
module vemt_host (
    input wire logic clock, // bench clock
    input wire logic sdaLvl, // resolved sda
    output logic sclOut, // stands high between frames
    output logic sdaDrv // 0 pulls sda low
);
    initial begin
        sclOut = 1'b1;
        sdaDrv = 1'b1;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clock);
    endtask : tick
    // sda moves only mid-low so no data bit looks like a start or stop
    task automatic bitio(input logic b, output logic s);
        tick(4);
        sdaDrv <= b;
        tick(4);
        sclOut <= 1'b1;
        tick(4);
        s = sdaLvl;
        tick(4);
        sclOut <= 1'b0;
    endtask : bitio
    task automatic frame(input logic stp);
        tick(4);
        sdaDrv <= ~stp;
        tick(8);
        sclOut <= 1'b1;
        tick(8);
        sdaDrv <= stp;
        tick(8);
        if (!stp) begin
            sclOut <= 1'b0;
        end
    endtask : frame
    task automatic xfer(input logic [7:0] tx, input logic last, output logic [7:0] rx,
        output logic nack);
        for (int i = 7; i >= 0; i--) begin
            bitio(tx[i], rx[i]);
        end
        bitio(last, nack);
    endtask : xfer
    task automatic wr(input logic [6:0] a, input logic [7:0] sub, input logic [7:0] d,
        output logic nack);
        logic [7:0] rx;
        logic [2:0] n;
        frame(1'b0);
        xfer({a, 1'b0}, 1'b1, rx, n[0]);
        xfer(sub, 1'b1, rx, n[1]);
        xfer(d, 1'b1, rx, n[2]);
        frame(1'b1);
        nack = |n;
    endtask : wr
    task automatic rd(input logic [6:0] a, input logic [7:0] sub, output logic [7:0] d);
        logic [7:0] rx;
        logic n;
        frame(1'b0);
        xfer({a, 1'b0}, 1'b1, rx, n);
        xfer(sub, 1'b1, rx, n);
        frame(1'b0);
        xfer({a, 1'b1}, 1'b1, rx, n);
        // refusing the last byte makes the device let go before the stop
        xfer(8'hff, 1'b1, d, n);
        frame(1'b1);
    endtask : rd
endmodule : vemt_host
`default_nettype wire

// *** verification/vemt_regs_chk.sv ***
// concurrent checks on the ports of the mode/timing bank
// assumes one clock domain, reset asynchronously by arst_n
`timescale 1ns/1ps
`default_nettype none
module vemt_regs_chk (
    input wire logic clock, // system clock
    input wire logic arst_n, // async reset
    input wire logic sclIn, // serial clock pin
    input wire logic sdaIn, // sda level
    input wire logic sdaOut, // sda drive value
    input wire logic sdaOe_n, // sda pull enable
    input wire logic palMode, // video standard
    input wire logic lineStart, // line start pulse
    input wire vemt_pkg::vemt_cfg_t cfg, // applied settings
    input wire logic sleepActive, // sleep state
    input wire logic timingCounterClear // counter clear pulse
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!arst_n);
    a_line_gate: assert property ($changed(cfg.timingMode) |-> $past(lineStart, 2))
        else $error("timing mode moved outside a line start");
    a_blank_slave: assert property (cfg.blankInputHonoured |-> !cfg.master)
        else $error("blank input honoured in master");
    a_vsync_length: assert property (cfg.vsyncHalfLines inside {3'h0, 3'h5, 3'h6})
        else $error("vsync length not 2.5 or 3 lines");
    a_edge_mode_one: assert property (cfg.timingMode != 2'h1 |-> cfg.hsyncFieldEdgeDelay == 2'h0)
        else $error("field edge delay outside mode 1");
    a_width_mode_two: assert property (cfg.timingMode != 2'h2 |-> cfg.vsyncWidthSel == 2'h0)
        else $error("vsync width outside mode 2");
    a_luma_step: assert property (cfg.lumaDelayCycles inside {4'h0, 4'h3, 4'h6, 4'h9})
        else $error("luma delay not a whole step");
    a_clear_pulse: assert property (timingCounterClear |-> !sclIn ##1 !timingCounterClear)
        else $error("counter clear not a single pulse");
    a_sleep_bus: assert property ($changed(sleepActive) |-> !sclIn)
        else $error("sleep changed outside a bus write");
    a_sda_phase: assert property ($changed(sdaOe_n) |-> !sclIn)
        else $error("sda drive changed while scl high");
    cover property ($rose(sleepActive));
    cover property (timingCounterClear);
    cover property (cfg.timingMode == 2'h2);
    cover property (!sdaOe_n && sclIn);
endmodule : vemt_regs_chk
bind vemt_regs vemt_regs_chk u_chk (.clock(clock), .arst_n(arst_n), .sclIn(sclIn),
    .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe_n(sdaOe_n), .palMode(palMode),
    .lineStart(lineStart), .cfg(cfg), .sleepActive(sleepActive),
    .timingCounterClear(timingCounterClear));
`default_nettype wire

// *** verification/vemt_regs_tb.sv ***
// self-checking bench for the mode/timing bank: table of settings, then hand tests
// assumes the host model vemt_host and the bound checker vemt_regs_chk
`timescale 1ns/1ps
`default_nettype none
module vemt_regs_tb;
    localparam logic [6:0] ADDR = 7'h2a; // arbitrary bus address
    // {reg04, reg07, reg08, 7'h0, palMode}: every timing mode and luma step once
    localparam logic [31:0] ROWS [4] = '{32'h3f081b00, 32'h18123901, 32'h1a25e400, 32'h253fff01};
    logic clock, arst_n, sclIn, sdaDrv, sdaOut, sdaOe_n, palMode, lineStart;
    logic sleepActive, timingCounterClear, nack;
    logic [7:0] rdData;
    logic [31:0] row;
    int failures, check_count, clears;
    vemt_pkg::vemt_cfg_t cfg, prev;
    // open-drain sda with a pull-up
    wire logic sdaLvl = sdaDrv & (sdaOe_n | sdaOut);
    vemt_regs #(.DEV_ADDR(ADDR)) u_dut (.clock(clock), .arst_n(arst_n), .sclIn(sclIn),
        .sdaIn(sdaLvl), .sdaOut(sdaOut), .sdaOe_n(sdaOe_n), .palMode(palMode),
        .lineStart(lineStart), .cfg(cfg), .sleepActive(sleepActive),
        .timingCounterClear(timingCounterClear));
    vemt_host u_host (.clock(clock), .sdaLvl(sdaLvl), .sclOut(sclIn), .sdaDrv(sdaDrv));
    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end
    always @(posedge clock) begin
        if (timingCounterClear === 1'b1) begin
            clears <= clears + 1;
        end
    end
    // luma step of 74 ns is three 25 ns clocks, rounded up
    function automatic vemt_pkg::vemt_cfg_t model(input logic [31:0] r);
        return {r[24], r[25], r[26], r[27] ? (r[0] ? 3'h5 : 3'h6) : 3'h0, r[28] & ~r[0],
            r[29], r[16], r[18:17], r[19] & ~r[16], {2'h0, r[21:20]} * 4'h3, r[22], r[9:8],
            r[11:10], (r[18:17] == 2'h1) ? r[13:12] : 2'h0,
            (r[18:17] == 2'h2) ? r[13:12] : 2'h0, r[15:14]};
    endfunction : model
    task automatic chkByte(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("Error at %0t: byte %h expected %h", $time, got, exp);
        end
    endtask : chkByte
    task automatic chkCfg(input vemt_pkg::vemt_cfg_t got, input vemt_pkg::vemt_cfg_t exp);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("Error at %0t: cfg %h expected %h", $time, got, exp);
        end
    endtask : chkCfg
    task automatic wrReg(input logic [7:0] sub, input logic [7:0] d);
        u_host.wr(ADDR, sub, d, nack);
        chkByte({7'h0, nack}, 8'h00);
    endtask : wrReg
    task automatic rdReg(input logic [7:0] sub, input logic [7:0] exp);
        u_host.rd(ADDR, sub, rdData);
        chkByte(rdData, exp);
    endtask : rdReg
    task automatic stop_test;
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : stop_test
    initial begin
        repeat (90000) @(posedge clock);
        failures++;
        $display("Error at %0t: run did not finish", $time);
        stop_test();
    end
    initial begin
        arst_n = 1'b0;
        palMode = 1'b0;
        lineStart = 1'b0;
        repeat (8) @(posedge clock);
        chkCfg(cfg, '0);
        chkByte({5'h0, sdaOe_n, sleepActive, timingCounterClear}, 8'h04);
        arst_n <= 1'b1;
        repeat (8) @(posedge clock);
        for (int i = 0; i < 4; i++) begin
            row = ROWS[i];
            prev = cfg;
            wrReg(8'h04, row[31:24]);
            wrReg(8'h07, row[23:16]);
            wrReg(8'h08, row[15:8]);
            rdReg(8'h04, row[31:24]);
            rdReg(8'h07, row[23:16]);
            rdReg(8'h08, row[15:8]);
            chkCfg(cfg, prev);
            palMode <= row[0];
            lineStart <= 1'b1;
            @(posedge clock);
            lineStart <= 1'b0;
            repeat (3) @(posedge clock);
            chkCfg(cfg, model(row));
            $display("row %0d done", i);
        end
        wrReg(8'h04, 8'h40);
        chkByte({7'h0, sleepActive}, 8'h01);
        wrReg(8'h08, 8'h5a);
        rdReg(8'h08, 8'h5a);
        wrReg(8'h04, 8'h00);
        chkByte({7'h0, sleepActive}, 8'h00);
        wrReg(8'h04, 8'h40);
        arst_n <= 1'b0;
        @(posedge clock);
        arst_n <= 1'b1;
        chkByte({7'h0, sleepActive}, 8'h00);
        repeat (8) @(posedge clock);
        rdReg(8'h04, 8'h00);
        rdReg(8'h07, 8'h00);
        rdReg(8'h08, 8'h00);
        $display("sleep test done");
        wrReg(8'h07, 8'h80);
        chkByte(clears[7:0], 8'h00);
        wrReg(8'h07, 8'h00);
        chkByte(clears[7:0], 8'h01);
        $display("counter clear test done");
        wrReg(8'h05, 8'hff);
        rdReg(8'h05, 8'h00);
        u_host.wr(7'h2b, 8'h04, 8'h40, nack);
        chkByte({7'h0, nack}, 8'h01);
        rdReg(8'h04, 8'h00);
        chkByte({7'h0, sleepActive}, 8'h00);
        $display("refusal test done");
        stop_test();
    end
endmodule : vemt_regs_tb
`default_nettype wire
